// >>> rtl/thermal_alarm_thermostat.sv
// thermostat core: conversion pacing, fault queue, alarm pin, register slave
`timescale 1ns/1ns
// Functional notes
// - temperature held as 16-bit signed value
// - code in bits 15..7, bits 6..0 zero
// - temperature readable anytime without disturbing conversion
// - each conversion compared, alarm updated
// - level bit selects alarm polarity, default low
// - comparator asserts after queue of over-limit faults
// - comparator releases at first under-release measurement
// - comparator alarm unchanged on entering standby
// - interrupt mode fires after queued over-limit faults
// - interrupt alarm cleared by register read
// - after clear, rearms on queued under-release faults
// - queue field 00/01/10/11 gives 1/2/4/6
// - alarm one period after count, fault persisting
// - standby finishes conversion, stores, stops converting
// - standby entry clears alarm in interrupt mode
// - registers work in standby; zero resumes
// - all values 9-bit signed, half-degree steps
// - reset defaults run thermostat standalone
// - mode bit 0 comparator, 1 interrupt
// - release resets 4B00, over-limit 5000
// - results always compared, stored once no read stands
module thermal_alarm_thermostat #(
    parameter int CONV_PERIOD_CYCLES = 1000
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire thermal_alarm_pkg::avmm_req_t i_avm,
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    input wire thermal_alarm_pkg::conv_t i_conv,
    output logic o_conv_start,
    output logic o_standby,
    input wire logic i_alarm_output,
    output logic o_alarm_output,
    output logic o_alarm_output_oe_n
);
    localparam int TW = $clog2(CONV_PERIOD_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_RELOAD = TW'(CONV_PERIOD_CYCLES - 1);

    function automatic logic [2:0] queue_need(input logic [1:0] sel);
        unique case (sel)
            2'b00: queue_need = 3'h1;
            2'b01: queue_need = 3'h2;
            2'b10: queue_need = 3'h4;
            2'b11: queue_need = 3'h6;
        endcase
    endfunction

    function automatic logic is_above(input logic [8:0] code, input logic [8:0] limit);
        is_above = $signed(code) > $signed(limit);
    endfunction

    function automatic logic is_below(input logic [8:0] code, input logic [8:0] limit);
        is_below = $signed(code) < $signed(limit);
    endfunction

    function automatic logic [15:0] widen(input logic [8:0] code);
        widen = {code, 7'h00};
    endfunction

    logic [15:0] temp;
    logic [7:0] conf;
    logic [15:0] release_setpoint;
    logic [15:0] over_limit_setpoint;
    logic alarm;
    logic next_alarm;
    thermal_alarm_pkg::seek_t seek;
    thermal_alarm_pkg::seek_t next_seek;
    logic [2:0] fault_count;
    logic [2:0] next_fault_count;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic busy;
    logic pending;
    logic [8:0] pending_code;
    logic [15:0] read_value;
    logic [15:0] status_value;

    // bus decode
    logic bus_req;
    logic bus_first;
    logic bus_done;
    logic write_done;
    logic read_done;
    logic device_read;
    logic [2:0] reg_index;
    logic conf_wr;
    logic release_wr;
    logic over_wr;

    assign bus_req = i_avm.read | i_avm.write;
    assign bus_first = bus_req & o_waitrequest;
    assign bus_done = bus_req & ~o_waitrequest;
    assign write_done = bus_done & i_avm.write;
    assign read_done = bus_done & i_avm.read;
    assign reg_index = i_avm.address[thermal_alarm_pkg::ADDR_W-1:2];
    // status view is not a device register
    assign device_read = read_done & (reg_index <= thermal_alarm_pkg::IDX_LAST_DEVICE);
    assign conf_wr = write_done & (reg_index == thermal_alarm_pkg::IDX_CONF) & i_avm.byteenable[0];
    assign release_wr = write_done & (reg_index == thermal_alarm_pkg::IDX_RELEASE) & i_avm.byteenable[1];
    assign over_wr = write_done & (reg_index == thermal_alarm_pkg::IDX_OVER) & i_avm.byteenable[1];

    // debug view, outside the four device registers
    assign status_value = {9'h000, fault_count, i_alarm_output, o_standby, busy, alarm};

    always_comb begin
        case (reg_index)
            thermal_alarm_pkg::IDX_TEMP: read_value = temp;
            thermal_alarm_pkg::IDX_CONF: read_value = {8'h00, conf};
            thermal_alarm_pkg::IDX_RELEASE: read_value = release_setpoint;
            thermal_alarm_pkg::IDX_OVER: read_value = over_limit_setpoint;
            thermal_alarm_pkg::IDX_STATUS: read_value = status_value;
            default: read_value = 16'h0000;
        endcase
    end

    // one wait state, answer stands one cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
        end else begin
            o_waitrequest <= ~bus_first;
            if (bus_first) begin
                o_readdata <= {16'h0000, read_value};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            conf <= thermal_alarm_pkg::CONF_RESET;
        end else if (conf_wr) begin
            conf <= i_avm.writedata[7:0] & thermal_alarm_pkg::CONF_WR_MASK;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            release_setpoint <= thermal_alarm_pkg::RELEASE_RESET;
        end else if (release_wr) begin
            release_setpoint <= widen(i_avm.writedata[15:7]);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            over_limit_setpoint <= thermal_alarm_pkg::OVER_RESET;
        end else if (over_wr) begin
            over_limit_setpoint <= widen(i_avm.writedata[15:7]);
        end
    end

    logic start_now;
    logic conv_done;
    logic standby_entry;
    assign next_timer = (timer == '0) ? TIMER_RELOAD : timer - TW'(1);
    assign start_now = (timer == '0) & ~conf[thermal_alarm_pkg::CFG_STANDBY] & ~busy;
    // a done without a start is ignored
    assign conv_done = i_conv.done & busy;
    // standby once the last result is in
    assign standby_entry = conf[thermal_alarm_pkg::CFG_STANDBY] & ~busy & ~o_standby;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            timer <= '0;
            busy <= 1'b0;
            o_conv_start <= 1'b0;
            o_standby <= 1'b0;
        end else begin
            timer <= next_timer;
            o_conv_start <= start_now;
            o_standby <= conf[thermal_alarm_pkg::CFG_STANDBY] & ~busy;
            if (start_now) begin
                busy <= 1'b1;
            end else if (conv_done) begin
                busy <= 1'b0;
            end
        end
    end

    // result held back while a read stands
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            temp <= thermal_alarm_pkg::TEMP_RESET;
            pending <= 1'b0;
            pending_code <= 9'h000;
        end else if (conv_done & ~i_avm.read) begin
            temp <= widen(i_conv.value);
            pending <= 1'b0;
        end else if (conv_done) begin
            pending <= 1'b1;
            pending_code <= i_conv.value;
        end else if (pending & ~i_avm.read) begin
            temp <= widen(pending_code);
            pending <= 1'b0;
        end
    end

    logic [8:0] over_code;
    logic [8:0] release_code;
    logic hot;
    logic cold;
    logic mode_interrupt;
    logic fault;
    logic queue_met;
    logic fire;
    logic comp_release;

    assign over_code = over_limit_setpoint[15:7];
    assign release_code = release_setpoint[15:7];
    assign hot = is_above(i_conv.value, over_code);
    assign cold = is_below(i_conv.value, release_code);
    assign mode_interrupt = conf[thermal_alarm_pkg::CFG_MODE];
    assign fault = (seek == thermal_alarm_pkg::SEEK_OVER) ? hot : cold;
    // fires one period past the queue, fault still there
    assign queue_met = fault_count >= queue_need(conf[thermal_alarm_pkg::CFG_QUEUE_HI:thermal_alarm_pkg::CFG_QUEUE_LO]);
    assign fire = conv_done & fault & queue_met;
    assign comp_release = conv_done & ~mode_interrupt & alarm & cold;

    always_comb begin
        next_fault_count = fault_count;
        next_seek = seek;
        if (conv_done) begin
            if (fire || !fault) begin
                next_fault_count = thermal_alarm_pkg::COUNT_RESET;
            end else begin
                next_fault_count = fault_count + 3'h1;
            end
            if (fire && mode_interrupt) begin
                if (seek == thermal_alarm_pkg::SEEK_OVER) begin
                    next_seek = thermal_alarm_pkg::SEEK_UNDER;
                end else begin
                    next_seek = thermal_alarm_pkg::SEEK_OVER;
                end
            end
        end
        if (conf_wr) begin
            next_fault_count = thermal_alarm_pkg::COUNT_RESET;
            next_seek = thermal_alarm_pkg::SEEK_OVER;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fault_count <= thermal_alarm_pkg::COUNT_RESET;
            seek <= thermal_alarm_pkg::SEEK_OVER;
        end else begin
            fault_count <= next_fault_count;
            seek <= next_seek;
        end
    end

    always_comb begin
        next_alarm = alarm;
        if (device_read & mode_interrupt) begin
            next_alarm = 1'b0;
        end
        // standby clears only in interrupt mode
        if (standby_entry & mode_interrupt) begin
            next_alarm = 1'b0;
        end
        if (comp_release) begin
            next_alarm = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (fire) begin
            next_alarm = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            alarm <= 1'b0;
        end else begin
            alarm <= next_alarm;
        end
    end

    // level bit picks which state pulls low
    logic drive_low;
    assign drive_low = conf[thermal_alarm_pkg::CFG_LEVEL] ? ~alarm : alarm;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_alarm_output <= 1'b0;
            o_alarm_output_oe_n <= 1'b1;
        end else begin
            o_alarm_output <= 1'b0;
            o_alarm_output_oe_n <= ~drive_low;
        end
    end

    AST_START_PULSE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_conv_start |=> !o_conv_start)
        else $error("conversion start longer than one cycle");

    AST_NO_START_STANDBY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_standby |-> !o_conv_start)
        else $error("conversion started during standby");

    AST_WAIT_ONE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");

    AST_UNUSED_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        temp[6:0] == 7'h00)
        else $error("temperature low bits not zero");

    AST_QUEUE_BOUND: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        fault_count <= 3'h6)
        else $error("fault count beyond deepest queue");

    AST_READ_CLEARS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (device_read && mode_interrupt && !fire) |=> !alarm)
        else $error("interrupt alarm survived a register read");

    AST_INT_STANDBY_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ($rose(o_standby) && $past(mode_interrupt)) |-> !alarm)
        else $error("interrupt alarm kept on entering standby");

    AST_COMP_STANDBY_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ($rose(o_standby) && !$past(mode_interrupt)) |-> (alarm == $past(alarm)))
        else $error("comparator alarm changed on entering standby");

    AST_DRIVE_LOW: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !o_alarm_output)
        else $error("alarm pin driven high");

    // main scenarios
    COV_COMP_FIRE: cover property (@(posedge i_ref_clk) disable iff (i_reset)
        fire && !mode_interrupt);
    COV_INT_FIRE: cover property (@(posedge i_ref_clk) disable iff (i_reset)
        fire && mode_interrupt);
    COV_READ_CLEAR: cover property (@(posedge i_ref_clk) disable iff (i_reset)
        device_read && mode_interrupt && alarm);
    COV_STANDBY: cover property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(o_standby));
endmodule // thermal_alarm_thermostat

// >>> inc/thermal_alarm_pkg.sv
// constants and carrier types of the thermal alarm thermostat
package thermal_alarm_pkg;
    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_TEMP = 3'h0;
    localparam logic [2:0] IDX_CONF = 3'h1;
    localparam logic [2:0] IDX_RELEASE = 3'h2;
    localparam logic [2:0] IDX_OVER = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;
    localparam logic [2:0] IDX_LAST_DEVICE = 3'h3;
    localparam int ADDR_W = 5;
    // configuration fields
    localparam int CFG_STANDBY = 0;
    localparam int CFG_MODE = 1;
    localparam int CFG_LEVEL = 2;
    localparam int CFG_QUEUE_LO = 3;
    localparam int CFG_QUEUE_HI = 4;
    localparam logic [7:0] CONF_WR_MASK = 8'h1F;
    // status fields
    localparam int ST_ALARM = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_STANDBY = 2;
    localparam int ST_PIN = 3;
    localparam int ST_COUNT_LO = 4;
    // values after reset
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] RELEASE_RESET = 16'h4B00;
    localparam logic [15:0] OVER_RESET = 16'h5000;
    // temperature code sits in bits 15..7
    localparam int TEMP_LSB = 7;
    localparam int TEMP_W = 9;
    localparam logic [2:0] COUNT_RESET = 3'h0;
    typedef enum logic {MODE_COMPARATOR, MODE_INTERRUPT} alarm_mode_t;
    typedef enum logic {SEEK_OVER, SEEK_UNDER} seek_t;
    typedef struct packed {
        logic done;
        logic [TEMP_W-1:0] value;
    } conv_t;
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avmm_req_t;
endpackage

// >>> tb/conv_model.sv
// converter stand-in giving one result per start
`timescale 1ns/1ns
module conv_model (
    input wire logic i_ref_clk,
    input wire logic i_start,
    input wire logic [8:0] i_value,
    output thermal_alarm_pkg::conv_t o_conv
);
    initial o_conv = '0;
    always @(posedge i_ref_clk) o_conv <= '{done: i_start, value: i_value};
endmodule // conv_model

// >>> tb/testbench.sv
// self-checking bench: register reads and results
`timescale 1ns/1ns
module testbench;
    logic i_ref_clk = 0, i_reset = 1, wr, stb, oe_n, pin, sb;
    logic [31:0] rd;
    logic [8:0] t = 9'h032;
    logic [15:0] expq[$];
    thermal_alarm_pkg::avmm_req_t avm = '0;
    thermal_alarm_pkg::conv_t conv;
    int fails = 0, total_checks = 0, seed = 75149;
    always #5 i_ref_clk = ~i_ref_clk;
    thermal_alarm_thermostat #(.CONV_PERIOD_CYCLES(40)) i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_avm(avm), .o_waitrequest(wr), .o_readdata(rd), .i_conv(conv), .o_conv_start(stb),
        .o_standby(sb), .i_alarm_output(oe_n | pin), .o_alarm_output(pin), .o_alarm_output_oe_n(oe_n));
    conv_model i_conv (.i_ref_clk(i_ref_clk), .i_start(stb), .i_value(t), .o_conv(conv));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_reg(input logic [2:0] idx, input logic [15:0] exp);
        expq.push_back(exp);
        @(posedge i_ref_clk) avm <= '{1'b1, 1'b0, {idx, 2'b00}, 4'hF, 32'h0};
        do @(posedge i_ref_clk); while (wr !== 1'b0);
        avm <= '0;
    endtask
    task automatic wr_reg(input logic [2:0] idx, input logic [15:0] data);
        @(posedge i_ref_clk) avm <= '{1'b0, 1'b1, {idx, 2'b00}, 4'hF, {16'h0000, data}};
        do @(posedge i_ref_clk); while (wr !== 1'b0);
        avm <= '0;
    endtask
    // five conversion periods at one temperature
    task automatic settle(input logic [8:0] code);
        t <= code;
        repeat (200) @(posedge i_ref_clk);
    endtask
    always @(posedge i_ref_clk) if (avm.read && wr === 1'b0) check("readdata", rd[15:0], expq.pop_front());
    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 0;
        rd_reg(3'h2, 16'h4B00);
        rd_reg(3'h3, 16'h5000);
        rd_reg(3'h1, 16'h0000);
        // spacing wider than a period so a result lands
        repeat (3) begin
            t <= 9'($random(seed));
            repeat (120) @(posedge i_ref_clk);
            rd_reg(3'h0, {t, 7'h00});
        end
        settle(9'h032);
        check("pin", {15'h0000, oe_n | pin}, 16'h0001);
        settle(9'h0B4);
        check("pin", {15'h0000, oe_n | pin}, 16'h0000);
        settle(9'h032);
        check("pin", {15'h0000, oe_n | pin}, 16'h0001);
        wr_reg(3'h1, 16'h0002);
        settle(9'h0B4);
        check("pin", {15'h0000, oe_n | pin}, 16'h0000);
        rd_reg(3'h1, 16'h0002);
        repeat (2) @(posedge i_ref_clk);
        check("pin", {15'h0000, oe_n | pin}, 16'h0001);
        settle(9'h032);
        check("pin", {15'h0000, oe_n | pin}, 16'h0000);
        wr_reg(3'h1, 16'h0003);
        repeat (100) @(posedge i_ref_clk);
        check("pin", {15'h0000, oe_n | pin}, 16'h0001);
        check("standby", {15'h0000, sb}, 16'h0001);
        wr_reg(3'h1, 16'h0000);
        repeat (5) @(posedge i_ref_clk);
        check("standby", {15'h0000, sb}, 16'h0000);
        wrap_up();
    end
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule // testbench
